// *** hdl/l1d_ctrl_pkg.sv ***
// Purpose: shared constants and types of the level-1 data side control
// Assumes: 32-bit physical addresses, 32-byte cache lines
// Notes: inner attribute codes follow the page descriptor encoding
package l1d_ctrl_pkg;
  // ----------------------------------------------------------------
  // load/store operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_LOAD,
    OP_PLAIN_STORE,
    OP_EXCL_LOAD,
    OP_EXCL_STORE,
    OP_CLEAR_EXCL
  } mem_op_t;
  typedef enum logic {MON_OPEN, MON_EXCL} mon_state_t;
  // ----------------------------------------------------------------
  // inner attributes
  // ----------------------------------------------------------------
  localparam logic [3:0] ATTR_STRONG = 4'h0;
  localparam logic [3:0] ATTR_WT = 4'h6;
  localparam logic [3:0] ATTR_WB_NWA = 4'h7;
  localparam logic [3:0] ATTR_WB_WA = 4'hF;
  // ----------------------------------------------------------------
  // address geometry, prefetch and parity constants
  // ----------------------------------------------------------------
  localparam int LINE_LSB = 5;
  localparam int PAGE_LSB = 12;
  localparam int LINE_W = 32 - LINE_LSB;
  localparam int PAGE_W = 32 - PAGE_LSB;
  localparam int STRIDE_W = 5;
  localparam logic [STRIDE_W-1:0] MAX_STRIDE = 5'h08;
  localparam logic [1:0] PF_CONFIRM = 2'h2;
  localparam int PARITY_LAT = 3;
endpackage

// *** hdl/l1_data_side_control.sv ***
// Purpose: exclusive monitor, abort routing, cacheability, prefetch and parity
// Assumes: all inputs come from logic on mclk; one operation per cycle
// Notes: access and abort answers come one cycle after the request; parity errors come PARITY_LAT cycles after the read
`timescale 1ns/100ps
module l1_data_side_control
  import l1d_ctrl_pkg::*;
#(
  parameter int STREAMS = 8,
  parameter int NRAM = 8,
  parameter int RAM_W = 64
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // configuration
  input wire logic dcacheEnableBit,
  input wire logic coherencyParticipationBit,
  input wire logic prefetchEnable,
  input wire logic parityEnable,
  // load/store pipeline access
  input wire logic accValid,
  input wire mem_op_t accOp,
  input wire logic [31:0] accAddr,
  input wire logic [1:0] accSize,
  input wire logic [3:0] accInner,
  input wire logic accShared,
  output logic accDone,
  output logic accCacheable,
  output logic accMemWrite,
  output logic exclStatus,
  output logic exclGlobalCheck,
  output logic [4:0] userSideband,
  // external aborts
  input wire logic extAbortValid,
  input wire logic [3:0] extAbortInner,
  output logic syncAbort,
  output logic asyncAbort,
  // barrier and context
  input wire logic dataSyncBarrier,
  input wire logic [3:0] barrierOption,
  input wire logic contextChange,
  output logic fullSystemBarrier,
  // preload hint
  input wire logic preloadDataHint,
  input wire logic [31:0] preloadAddr,
  output logic preloadBusy,
  // cache events seen by the prefetcher
  input wire logic missValid,
  input wire logic [31:0] missAddr,
  input wire logic hitValid,
  input wire logic [31:0] hitAddr,
  // line request towards the level-2 side
  output logic lineReqValid,
  output logic [LINE_W-1:0] lineReqLine,
  output logic lineReqIsPreload,
  input wire logic lineReqReady,
  // ram parity
  input wire logic [RAM_W-1:0] ramWrData,
  output logic [(RAM_W+7)/8-1:0] ramWrParity,
  input wire logic [NRAM-1:0] ramRdValid,
  input wire logic [NRAM*RAM_W-1:0] ramRdData,
  input wire logic [NRAM*((RAM_W+7)/8)-1:0] ramRdParity,
  output logic [NRAM-1:0] ramParityErrorPulse
);
  localparam int PW = (RAM_W + 7) / 8;
  localparam int SIDX_W = (STREAMS > 1) ? $clog2(STREAMS) : 1;

  if (STREAMS < 1 || STREAMS > 16 || NRAM < 1 || RAM_W < 1) begin : gBadParams
    $error("l1_data_side_control: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [PW-1:0] parity_of(input logic [RAM_W-1:0] d);
    logic [PW-1:0] p;
    p = '0;
    for (int b = 0; b < RAM_W; b++) begin
      p[b/8] = p[b/8] ^ d[b];
    end
    return p;
  endfunction

  function automatic logic [3:0] size_bytes(input logic [1:0] sz);
    return 4'h1 << sz;
  endfunction

  function automatic logic [PAGE_W-1:0] page_of_line(input logic [LINE_W-1:0] l);
    return l[LINE_W-1:PAGE_LSB-LINE_LSB];
  endfunction

  // ----------------------------------------------------------------
  // exclusive monitor
  // ----------------------------------------------------------------
  mon_state_t monState;
  logic [LINE_W-1:0] tagLine;
  logic [LINE_LSB-1:0] tagOff;
  logic [1:0] tagSize;

  wire isExclSt = accValid && (accOp == OP_EXCL_STORE);
  wire isExclLd = accValid && (accOp == OP_EXCL_LOAD);
  wire isClear = accValid && (accOp == OP_CLEAR_EXCL);
  wire isPlainSt = accValid && (accOp == OP_PLAIN_STORE);
  wire granuleHit = accAddr[31:LINE_LSB] == tagLine;
  wire [5:0] tagEnd = {1'b0, tagOff} + {2'h0, size_bytes(tagSize)};
  wire [5:0] stEnd = {1'b0, accAddr[LINE_LSB-1:0]} + {2'h0, size_bytes(accSize)};
  wire bytesInside = (tagOff >= accAddr[LINE_LSB-1:0]) && (tagEnd <= stEnd);
  wire sizeOk = (accSize == tagSize) || bytesInside;
  wire exclPass = (monState == MON_EXCL) && granuleHit && sizeOk;
  wire isWriteBack = (accInner == ATTR_WB_WA) || (accInner == ATTR_WB_NWA);
  wire localOnly = isWriteBack && (!accShared || coherencyParticipationBit);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      monState <= MON_OPEN;
      tagLine <= '0;
      tagOff <= '0;
      tagSize <= '0;
    end else if (isExclLd) begin
      monState <= MON_EXCL;
      tagLine <= accAddr[31:LINE_LSB];
      tagOff <= accAddr[LINE_LSB-1:0];
      tagSize <= accSize;
    end else if (isExclSt || isClear) begin
      monState <= MON_OPEN;
    end
    // plain stores fall through and keep the monitor as it is
  end

  // ----------------------------------------------------------------
  // cacheability and access answer
  // ----------------------------------------------------------------
  wire descCacheable = isWriteBack || (accInner == ATTR_WT);
  wire treatCached = dcacheEnableBit && descCacheable
    && (accInner != ATTR_WT)
    && !(accShared && !coherencyParticipationBit);
  wire next_memWrite = isPlainSt || (isExclSt && exclPass);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      accDone <= 1'b0;
      accCacheable <= 1'b0;
      accMemWrite <= 1'b0;
      exclStatus <= 1'b0;
      exclGlobalCheck <= 1'b0;
      userSideband <= '0;
    end else begin
      accDone <= accValid;
      accCacheable <= accValid && !isClear && treatCached;
      accMemWrite <= next_memWrite;
      exclStatus <= isExclSt && !exclPass;
      exclGlobalCheck <= (isExclLd || isExclSt) && !localOnly;
      if (accValid) begin
        userSideband <= {accInner, accShared};
      end
    end
  end

  // ----------------------------------------------------------------
  // aborts and barrier
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncAbort <= 1'b0;
      asyncAbort <= 1'b0;
      fullSystemBarrier <= 1'b0;
    end else begin
      syncAbort <= extAbortValid && (extAbortInner == ATTR_STRONG);
      asyncAbort <= extAbortValid && (extAbortInner != ATTR_STRONG);
      // option field deliberately ignored
      fullSystemBarrier <= dataSyncBarrier;
    end
  end

  // ----------------------------------------------------------------
  // preload unit and line request arbitration
  // ----------------------------------------------------------------
  logic [LINE_W-1:0] pldLine;
  logic [STREAMS-1:0] sValid, sActive, sPend;
  logic [LINE_W-1:0] sLine [STREAMS];
  logic [LINE_W-1:0] sNext [STREAMS];
  logic [STRIDE_W-1:0] sStride [STREAMS];
  logic [1:0] sConf [STREAMS];
  logic [SIDX_W-1:0] victim;

  // preload is taken only while no earlier one waits; the pipeline holds it
  wire pldTake = preloadDataHint && !preloadBusy;
  wire issueSlot = !lineReqValid || lineReqReady;
  wire issuePld = issueSlot && preloadBusy;
  wire anyPend = |sPend;
  wire issuePf = issueSlot && !preloadBusy && anyPend;
  logic [SIDX_W-1:0] pendIdx;
  always_comb begin
    pendIdx = '0;
    for (int i = STREAMS - 1; i >= 0; i--) begin
      if (sPend[i]) begin
        pendIdx = SIDX_W'(i);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      preloadBusy <= 1'b0;
      pldLine <= '0;
    end else if (pldTake) begin
      preloadBusy <= 1'b1;
      pldLine <= preloadAddr[31:LINE_LSB];
    end else if (issuePld) begin
      preloadBusy <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lineReqValid <= 1'b0;
      lineReqLine <= '0;
      lineReqIsPreload <= 1'b0;
    end else if (issueSlot) begin
      lineReqValid <= preloadBusy || anyPend;
      lineReqIsPreload <= preloadBusy;
      lineReqLine <= preloadBusy ? pldLine : sNext[pendIdx];
    end
  end

  // ----------------------------------------------------------------
  // stride prefetcher
  // ----------------------------------------------------------------
  wire [LINE_W-1:0] mLine = missAddr[31:LINE_LSB];
  wire [LINE_W-1:0] hLine = hitAddr[31:LINE_LSB];
  // barrier, preload and context change end every stream
  wire stopAll = dataSyncBarrier || pldTake || contextChange || !prefetchEnable;
  logic [STREAMS-1:0] pageMatch;
  logic anyMatch;
  logic [SIDX_W-1:0] matchIdx;
  always_comb begin
    anyMatch = 1'b0;
    matchIdx = '0;
    for (int i = STREAMS - 1; i >= 0; i--) begin
      pageMatch[i] = sValid[i] && (page_of_line(sLine[i]) == page_of_line(mLine));
      if (pageMatch[i]) begin
        anyMatch = 1'b1;
        matchIdx = SIDX_W'(i);
      end
    end
  end

  wire [LINE_W-1:0] dFull = mLine - sLine[matchIdx];
  wire [STRIDE_W-1:0] delta = dFull[STRIDE_W-1:0];
  wire [STRIDE_W-1:0] dMag = delta[STRIDE_W-1] ? STRIDE_W'(-delta) : delta;
  wire dUpper = &dFull[LINE_W-1:STRIDE_W-1] || ~|dFull[LINE_W-1:STRIDE_W-1];
  wire strideOk = dUpper && (delta != '0) && (dMag <= MAX_STRIDE);
  wire [LINE_W-1:0] dExt = {{(LINE_W - STRIDE_W){delta[STRIDE_W-1]}}, delta};
  wire [LINE_W-1:0] firstPf = mLine + dExt;
  wire newStream = missValid && !anyMatch;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      victim <= '0;
    end else if (newStream && !stopAll) begin
      victim <= (victim == SIDX_W'(STREAMS - 1)) ? '0 : victim + 1'b1;
    end
  end

  for (genvar g = 0; g < STREAMS; g++) begin : gStream
    wire [LINE_W-1:0] stepExt = {{(LINE_W - STRIDE_W){sStride[g][STRIDE_W-1]}}, sStride[g]};
    wire [LINE_W-1:0] nextStep = sNext[g] + stepExt;
    wire hitHere = hitValid && sActive[g] && (hLine == sNext[g]);
    wire missHere = missValid && anyMatch && (matchIdx == SIDX_W'(g));
    wire confirmHit = strideOk && (delta == sStride[g]);
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        sValid[g] <= 1'b0;
        sActive[g] <= 1'b0;
        sPend[g] <= 1'b0;
        sLine[g] <= '0;
        sNext[g] <= '0;
        sStride[g] <= '0;
        sConf[g] <= '0;
      end else if (stopAll) begin
        sActive[g] <= 1'b0;
        sPend[g] <= 1'b0;
        sConf[g] <= '0;
      end else if (newStream && victim == SIDX_W'(g)) begin
        sValid[g] <= 1'b1;
        sActive[g] <= 1'b0;
        sPend[g] <= 1'b0;
        sLine[g] <= mLine;
        sStride[g] <= '0;
        sConf[g] <= '0;
      end else if (missHere) begin
        sLine[g] <= mLine;
        if (sActive[g]) begin
          // program left the prefetched lines
          sActive[g] <= 1'b0;
          sPend[g] <= 1'b0;
          sConf[g] <= '0;
        end else if (confirmHit && sConf[g] + 2'h1 >= PF_CONFIRM) begin
          sActive[g] <= 1'b1;
          sNext[g] <= firstPf;
          sPend[g] <= page_of_line(firstPf) == page_of_line(mLine);
        end else if (confirmHit) begin
          sConf[g] <= sConf[g] + 2'h1;
        end else begin
          sStride[g] <= strideOk ? delta : '0;
          sConf[g] <= '0;
        end
      end else if (hitHere) begin
        // keep running while prefetched lines are used
        sNext[g] <= nextStep;
        sActive[g] <= page_of_line(nextStep) == page_of_line(sNext[g]);
        sPend[g] <= page_of_line(nextStep) == page_of_line(sNext[g]);
      end else if (issuePf && pendIdx == SIDX_W'(g)) begin
        sPend[g] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // ram parity
  // ----------------------------------------------------------------
  // fixed latency shift keeps the error pulse aligned to the read
  logic [NRAM-1:0] parPipe [PARITY_LAT];
  logic [NRAM-1:0] parErrNow;
  always_comb begin
    for (int r = 0; r < NRAM; r++) begin
      parErrNow[r] = parityEnable && ramRdValid[r]
        && (parity_of(ramRdData[r*RAM_W +: RAM_W]) != ramRdParity[r*PW +: PW]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ramWrParity <= '0;
      for (int s = 0; s < PARITY_LAT; s++) begin
        parPipe[s] <= '0;
      end
    end else begin
      ramWrParity <= parityEnable ? parity_of(ramWrData) : '0;
      parPipe[0] <= parErrNow;
      for (int s = 1; s < PARITY_LAT; s++) begin
        parPipe[s] <= parPipe[s-1];
      end
    end
  end

  assign ramParityErrorPulse = parPipe[PARITY_LAT-1];
endmodule

// *** tb/l1d_ctrl_asserts.sv ***
// Purpose: concurrent checks on the data side control ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached to every instance of the control block by bind
`timescale 1ns/100ps
module l1d_ctrl_asserts
  import l1d_ctrl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // access side
  input wire logic dcacheEnableBit,
  input wire logic coherencyParticipationBit,
  input wire logic accValid,
  input wire mem_op_t accOp,
  input wire logic [3:0] accInner,
  input wire logic accShared,
  input wire logic accCacheable,
  input wire logic accMemWrite,
  input wire logic exclStatus,
  input wire logic [4:0] userSideband,
  // aborts, barrier, line requests
  input wire logic extAbortValid,
  input wire logic [3:0] extAbortInner,
  input wire logic syncAbort,
  input wire logic asyncAbort,
  input wire logic dataSyncBarrier,
  input wire logic fullSystemBarrier,
  input wire logic lineReqValid,
  input wire logic [LINE_W-1:0] lineReqLine,
  input wire logic lineReqReady
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_sync_abort:
    assert property (extAbortValid && extAbortInner == ATTR_STRONG |=> syncAbort && !asyncAbort)
    else $error("strongly-ordered abort not synchronous");
  a_async_abort:
    assert property (extAbortValid && extAbortInner != ATTR_STRONG |=> asyncAbort && !syncAbort)
    else $error("abort not asynchronous");
  a_barrier_full:
    assert property (dataSyncBarrier |=> fullSystemBarrier) else $error("barrier not full");
  a_sideband_copy:
    assert property (accValid |=> userSideband == {$past(accInner), $past(accShared)})
    else $error("sideband differs from descriptor");
  a_off_uncached:
    assert property (accValid && !dcacheEnableBit |=> !accCacheable) else $error("cached while off");
  a_wt_uncached:
    assert property (accValid && accInner == ATTR_WT |=> !accCacheable)
    else $error("write-through cached");
  a_shared_uncached:
    assert property (accValid && accShared && !coherencyParticipationBit |=> !accCacheable)
    else $error("shared page cached");
  a_excl_result:
    assert property (accValid && accOp == OP_EXCL_STORE |=> accMemWrite != exclStatus)
    else $error("exclusive store result inconsistent");
  a_clear_quiet:
    assert property (accValid && accOp == OP_CLEAR_EXCL |=> !accMemWrite && !exclStatus)
    else $error("clear touched memory");
  a_req_hold:
    assert property (lineReqValid && !lineReqReady |=> lineReqValid && $stable(lineReqLine))
    else $error("line request dropped");
endmodule
bind l1_data_side_control l1d_ctrl_asserts u_asserts (.*);

// *** tb/l2_side_model.sv ***
// Purpose: level-2 side taking line requests
// Assumes: requests held until ready
// Notes: slow mode accepts one beat in four
`timescale 1ns/100ps
module l2_side_model
  import l1d_ctrl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic slow,
  // line request
  input wire logic lineReqValid,
  input wire logic [LINE_W-1:0] lineReqLine,
  input wire logic lineReqIsPreload,
  output logic lineReqReady,
  // record of accepted requests
  output logic [7:0] gotCount,
  output logic [LINE_W-1:0] gotLine,
  output logic gotPreload
);
  logic [1:0] phase;
  assign lineReqReady = !slow || phase == 2'h3;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase <= 2'h0;
      gotCount <= 8'h00;
      gotLine <= '0;
      gotPreload <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      if (lineReqValid && lineReqReady) begin
        gotCount <= gotCount + 8'h01;
        gotLine <= lineReqLine;
        gotPreload <= lineReqIsPreload;
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the data side control
// Assumes: RAM width 12, so each RAM has one leftover parity bit
// Notes: inputs change by non-blocking assignment at rising edges, except slow, which is cleared 1 ns after one
`timescale 1ns/100ps
module testbench;
  import l1d_ctrl_pkg::*;
  logic mclk, rst_n, slow, dcacheEnableBit, coherencyParticipationBit, prefetchEnable;
  logic parityEnable, accValid, accShared, accDone, accCacheable, accMemWrite, exclStatus;
  logic exclGlobalCheck, extAbortValid, syncAbort, asyncAbort, dataSyncBarrier, contextChange;
  logic fullSystemBarrier, preloadDataHint, preloadBusy, missValid, hitValid, lineReqValid;
  logic lineReqIsPreload, lineReqReady, gotPreload;
  mem_op_t accOp;
  logic [31:0] accAddr, preloadAddr, missAddr, hitAddr;
  logic [1:0] accSize, ramWrParity;
  logic [3:0] accInner, extAbortInner, barrierOption;
  logic [4:0] userSideband;
  logic [LINE_W-1:0] lineReqLine, gotLine;
  logic [7:0] gotCount, ramRdValid, ramParityErrorPulse;
  logic [11:0] ramWrData;
  logic [95:0] ramRdData;
  logic [15:0] ramRdParity;
  int fails, n_checks, cycles;
  l1_data_side_control #(.RAM_W(12)) dut (.*);
  l2_side_model partner (.*);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input mem_op_t op, input logic [31:0] a, input logic [1:0] sz);
    @(posedge mclk);
    accValid <= 1'b1;
    accOp <= op;
    accAddr <= a;
    accSize <= sz;
    @(posedge mclk);
    accValid <= 1'b0;
    #1;
    chk("done", 1, accDone);
  endtask
  task automatic xres(input logic w);
    chk("mem write", w, accMemWrite);
    chk("excl status", !w, exclStatus);
  endtask
  task automatic ev(input logic hit, input logic [31:0] a);
    @(posedge mclk);
    hitValid <= hit;
    missValid <= !hit;
    hitAddr <= a;
    missAddr <= a;
    @(posedge mclk);
    hitValid <= 1'b0;
    missValid <= 1'b0;
  endtask
  task automatic waitReq(input logic [7:0] n, input logic [31:0] line, input logic pre);
    for (int i = 0; i < 40 && gotCount !== n; i++) @(posedge mclk);
    repeat (6) @(posedge mclk);
    #1;
    chk("line count", n, gotCount);
    chk("line", line, gotLine);
    chk("preload", pre, gotPreload);
  endtask
  task automatic pulse4(input logic [31:0] base);
    for (int i = 0; i < 4; i++) ev(1'b0, base + 32'(i) * 32'h40);
  endtask
  task automatic barrier(input logic [3:0] o);
    @(posedge mclk);
    dataSyncBarrier <= 1'b1;
    barrierOption <= o;
    @(posedge mclk);
    dataSyncBarrier <= 1'b0;
    #1;
    chk("full barrier", 1, fullSystemBarrier);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_monitor;
    acc(OP_EXCL_LOAD, 32'h0000_2004, 2'h2);
    acc(OP_PLAIN_STORE, 32'h0000_2010, 2'h2);
    chk("plain write", 1, accMemWrite);
    acc(OP_EXCL_STORE, 32'h0000_201C, 2'h2);
    xres(1'b1);
    acc(OP_EXCL_STORE, 32'h0000_2004, 2'h2);
    xres(1'b0);
    acc(OP_EXCL_LOAD, 32'h0000_2004, 2'h2);
    acc(OP_EXCL_STORE, 32'h0000_2024, 2'h2);
    xres(1'b0);
  endtask
  task automatic t_size;
    acc(OP_EXCL_LOAD, 32'h0000_2006, 2'h0);
    acc(OP_EXCL_STORE, 32'h0000_2004, 2'h2);
    xres(1'b1);
    acc(OP_EXCL_LOAD, 32'h0000_2004, 2'h2);
    acc(OP_EXCL_STORE, 32'h0000_2004, 2'h0);
    xres(1'b0);
  endtask
  task automatic t_clear;
    acc(OP_EXCL_LOAD, 32'h0000_2000, 2'h2);
    acc(OP_CLEAR_EXCL, 32'h0000_2000, 2'h2);
    chk("clear write", 0, accMemWrite);
    acc(OP_EXCL_STORE, 32'h0000_2000, 2'h2);
    xres(1'b0);
  endtask
  task automatic t_attr;
    // enable, coherency, inner, shared, cacheable, global check
    logic [8:0] tbl [6] = '{9'h17A, 9'h078, 9'h131, 9'h13D, 9'h1BE, 9'h199};
    foreach (tbl[i]) begin
      @(posedge mclk);
      dcacheEnableBit <= tbl[i][8];
      coherencyParticipationBit <= tbl[i][7];
      accInner <= tbl[i][6:3];
      accShared <= tbl[i][2];
      acc(OP_EXCL_LOAD, 32'h0000_3000, 2'h2);
      chk("cacheable", tbl[i][1], accCacheable);
      chk("global check", tbl[i][0], exclGlobalCheck);
      chk("sideband", tbl[i][6:2], userSideband);
    end
    acc(OP_CLEAR_EXCL, 32'h0000_3000, 2'h2);
  endtask
  task automatic t_abort;
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
    foreach (codes[i]) begin
      @(posedge mclk);
      extAbortValid <= 1'b1;
      extAbortInner <= codes[i];
      @(posedge mclk);
      extAbortValid <= 1'b0;
      #1;
      chk("sync abort", codes[i] == 4'h0, syncAbort);
      chk("async abort", codes[i] != 4'h0, asyncAbort);
    end
    for (int o = 0; o < 16; o++) barrier(4'(o));
  endtask
  task automatic t_prefetch;
    pulse4(32'h0000_1000);
    waitReq(8'h01, 32'h88, 1'b0);
    ev(1'b1, 32'h0000_1100);
    waitReq(8'h02, 32'h8A, 1'b0);
    barrier(4'hF);
    ev(1'b1, 32'h0000_1140);
    waitReq(8'h02, 32'h8A, 1'b0);
    pulse4(32'h0000_3F00);
    waitReq(8'h02, 32'h8A, 1'b0);
    for (int i = 0; i < 3; i++) ev(1'b0, 32'h0000_5000 + 32'(i) * 32'h40);
    @(posedge mclk);
    contextChange <= 1'b1;
    @(posedge mclk);
    contextChange <= 1'b0;
    ev(1'b0, 32'h0000_50C0);
    waitReq(8'h02, 32'h8A, 1'b0);
  endtask
  task automatic t_preload;
    @(posedge mclk);
    slow <= 1'b1;
    pulse4(32'h0000_9000);
    for (int i = 0; i < 20 && lineReqValid !== 1'b1; i++) @(posedge mclk);
    preloadDataHint <= 1'b1;
    preloadAddr <= 32'h0000_7010;
    // hint is taken at the first edge that sees no preload waiting
    @(posedge mclk);
    while (preloadBusy === 1'b1) @(posedge mclk);
    preloadDataHint <= 1'b0;
    #1;
    chk("preload busy", 1, preloadBusy);
    waitReq(8'h04, 32'h380, 1'b1);
    slow <= 1'b0;
  endtask
  task automatic t_parity;
    @(posedge mclk);
    ramWrData <= 12'hA01;
    @(posedge mclk);
    ramWrData <= 12'h000;
    #1;
    chk("write parity", 2'h1, ramWrParity);
    @(posedge mclk);
    ramRdValid <= 8'h09;
    ramRdData[11:0] <= 12'h001;
    ramRdParity[1:0] <= 2'h1;
    ramRdData[47:36] <= 12'h001;
    #1;
    chk("zero parity", 2'h0, ramWrParity);
    @(posedge mclk);
    ramRdValid <= 8'h00;
    for (int k = 1; k < 5; k++) begin
      @(posedge mclk);
      #1;
      chk("parity pulse", k == 2 ? 8'h08 : 8'h00, ramParityErrorPulse);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    {rst_n, slow, accValid, accShared, extAbortValid, dataSyncBarrier, contextChange} = '0;
    {preloadDataHint, missValid, hitValid, coherencyParticipationBit} = '0;
    {dcacheEnableBit, prefetchEnable, parityEnable} = 3'h7;
    accOp = OP_LOAD;
    {accAddr, preloadAddr, missAddr, hitAddr, accSize, extAbortInner, barrierOption} = '0;
    accInner = ATTR_WB_WA;
    {ramWrData, ramRdValid, ramRdData, ramRdParity} = '0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_monitor();
    t_size();
    t_clear();
    t_attr();
    t_abort();
    t_prefetch();
    t_preload();
    t_parity();
    finish_test();
  end
endmodule
